// *** hw/tlps_scheduler.sv ***
// two-level process scheduler: dispatch, timeslicing, error flag save and halt
// Operation
// - low priority runs only when no high priority process is ready or running
// - high priority process keeps processor until it waits or terminates
// - waiting processes are absent from queues and never dispatched
// - low priority processes timesliced every 5120 reference clock cycles
// - low process gets one to two periods, then rejoins queue tail
// - ready high priority process pre-empts low work within 53 cycles
// - failed runtime check sets the single error flag
// - halt-on-error option stops dispatching once the flag is set
// - after an error halt links keep running, state stays for analysis
// - pre-emption saves a copy of the error flag, live flag kept
// - resuming pre-empted low process restores saved error flag
// - link engines run concurrently, never stalled by the scheduler
`timescale 1ns/100ps
`default_nettype none
module tlps_scheduler
(
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset,
	// reference_input_clock, one pulse per cycle of it
	input  wire logic                        refTick,
	// process becomes ready (channel, timer or start)
	input  wire logic                        readyValid,
	output logic                             readyAccept,
	input  wire logic [tlps_pkg::ID_W-1:0]   readyId,
	input  wire logic                        readyPri,
	// events from the running process
	input  wire logic                        procWait,
	input  wire logic                        procEnd,
	input  wire logic                        checkFail,
	input  wire logic                        errorClear,
	// initialisation option
	input  wire logic                        haltOnError,
	// dispatch state
	output logic                             runValid,
	output logic [tlps_pkg::ID_W-1:0]        runId,
	output logic                             runPri,
	output logic                             dispatch,
	// error and system status
	output logic                             errorFlag,
	output logic                             halted,
	output logic                             linkRun
);
	typedef struct packed
	{
		tlps_pkg::tlps_state_t       state;
		logic [tlps_pkg::ID_W-1:0]   runId;
		logic                        preempted;
		logic [tlps_pkg::ID_W-1:0]   preemptId;
		logic                        errorFlag;
		logic                        savedError;
		logic [12:0]                 sliceCount;
		logic                        boundarySeen;
		logic                        dispatch;
	} tlps_sched_t;

	tlps_sched_t s;
	tlps_sched_t next_s;

	logic                      hiPushValid;
	logic                      hiPushReady;
	logic                      hiValid;
	logic                      hiPop;
	logic [tlps_pkg::ID_W-1:0] hiId;
	logic                      loPushValid;
	logic                      loPushReady;
	logic [tlps_pkg::ID_W-1:0] loPushId;
	logic                      loValid;
	logic                      loPop;
	logic [tlps_pkg::ID_W-1:0] loId;
	logic                      requeue;
	logic                      boundary;
	logic                      free;

	tlps_proc_queue u_hiQueue
	(
		.clk       (clk),
		.reset     (reset),
		.pushValid (hiPushValid),
		.pushReady (hiPushReady),
		.pushId    (readyId),
		.popValid  (hiValid),
		.popReady  (hiPop),
		.popId     (hiId)
	);

	tlps_proc_queue u_loQueue
	(
		.clk       (clk),
		.reset     (reset),
		.pushValid (loPushValid),
		.pushReady (loPushReady),
		.pushId    (loPushId),
		.popValid  (loValid),
		.popReady  (loPop),
		.popId     (loId)
	);

	assign boundary = refTick && (s.sliceCount == tlps_pkg::SLICE_LAST);

	// a sliced process owns the low push port; a new low arrival waits a cycle
	assign loPushId = requeue ? s.runId : readyId;
	assign loPushValid = requeue || (readyValid && readyPri == tlps_pkg::PRI_LOW);
	assign hiPushValid = readyValid && readyPri == tlps_pkg::PRI_HIGH;
	assign readyAccept = (readyPri == tlps_pkg::PRI_HIGH) ? hiPushReady : (loPushReady && !requeue);

	always_comb
	begin
		next_s = s;
		hiPop = 1'b0;
		loPop = 1'b0;
		requeue = 1'b0;
		free = 1'b0;
		next_s.dispatch = 1'b0;

		// period counter runs regardless of what is running
		if (refTick)
			next_s.sliceCount = boundary ? tlps_pkg::SLICE_RESET : s.sliceCount + 13'h0001;

		unique case (s.state)
			tlps_pkg::S_IDLE:
				free = 1'b1;
			tlps_pkg::S_RUN_HI:
			begin
				if (procWait || procEnd)
					free = 1'b1;
			end
			tlps_pkg::S_RUN_LO:
			begin
				if (boundary)
					next_s.boundarySeen = 1'b1;
				if (procWait || procEnd)
					free = 1'b1;
				else if (hiValid)
				begin
					// pre-empt: the low process is parked, not requeued
					next_s.preempted = 1'b1;
					next_s.preemptId = s.runId;
					next_s.savedError = s.errorFlag;
					free = 1'b1;
				end
				else if (boundary && s.boundarySeen)
				begin
					// second boundary seen gives between one and two periods
					requeue = 1'b1;
					free = 1'b1;
				end
			end
			tlps_pkg::S_HALTED:
				free = 1'b0;
		endcase

		if (free)
		begin
			next_s.state = tlps_pkg::S_IDLE;
			if (hiValid)
			begin
				hiPop = 1'b1;
				next_s.state = tlps_pkg::S_RUN_HI;
				next_s.runId = hiId;
				next_s.dispatch = 1'b1;
			end
			else if (next_s.preempted)
			begin
				// live flag from high priority work is discarded here
				next_s.preempted = 1'b0;
				next_s.state = tlps_pkg::S_RUN_LO;
				next_s.runId = next_s.preemptId;
				next_s.errorFlag = next_s.savedError;
				next_s.dispatch = 1'b1;
			end
			else if (loValid && !requeue)
			begin
				// no low pick in a requeue cycle, so a requeued process is never re-picked at once
				loPop = 1'b1;
				next_s.state = tlps_pkg::S_RUN_LO;
				next_s.runId = loId;
				next_s.boundarySeen = 1'b0;
				next_s.dispatch = 1'b1;
			end
		end
		else if (s.state != tlps_pkg::S_HALTED)
		begin
			// a set arriving with a clear wins
			if (errorClear)
				next_s.errorFlag = 1'b0;
			if (checkFail)
				next_s.errorFlag = 1'b1;
		end

		if (haltOnError && next_s.errorFlag && s.state != tlps_pkg::S_HALTED)
		begin
			// a dequeue of this cycle still takes effect; only state and dispatch are overridden
			next_s.state = tlps_pkg::S_HALTED;
			next_s.dispatch = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			s.state <= tlps_pkg::S_IDLE;
			s.runId <= '0;
			s.preempted <= 1'b0;
			s.preemptId <= '0;
			s.errorFlag <= 1'b0;
			s.savedError <= 1'b0;
			s.sliceCount <= tlps_pkg::SLICE_RESET;
			s.boundarySeen <= 1'b0;
			s.dispatch <= 1'b0;
		end
		else
			s <= next_s;
	end

	assign runValid = (s.state == tlps_pkg::S_RUN_HI) || (s.state == tlps_pkg::S_RUN_LO);
	assign runId = s.runId;
	assign runPri = (s.state == tlps_pkg::S_RUN_LO) ? tlps_pkg::PRI_LOW : tlps_pkg::PRI_HIGH;
	assign dispatch = s.dispatch;
	assign errorFlag = s.errorFlag;
	assign halted = (s.state == tlps_pkg::S_HALTED);
	// link engines have their own memory port and never wait on dispatch
	assign linkRun = 1'b1;
endmodule : tlps_scheduler
`default_nettype wire

// *** shared/tlps_pkg.sv ***
// constants and types shared by the two-level process scheduler
package tlps_pkg;
	localparam int ID_W = 4;
	localparam int QUEUE_DEPTH = 16;
	localparam int PTR_W = 5;

	localparam logic PRI_HIGH = 1'b0;
	localparam logic PRI_LOW = 1'b1;

	// timeslice period counted in reference_input_clock cycles
	localparam int SLICE_REF_CYCLES = 5120;
	localparam logic [12:0] SLICE_LAST = 13'(SLICE_REF_CYCLES - 1);
	localparam logic [12:0] SLICE_RESET = 13'h0000;

	// resume latency bounds in processor cycles; this design dispatches two cycles after ready
	localparam int LATENCY_TYP_CYC = 19;
	localparam int LATENCY_MAX_CYC = 53;

	typedef enum logic [1:0]
	{
		S_IDLE = 2'b00,
		S_RUN_LO = 2'b01,
		S_RUN_HI = 2'b11,
		S_HALTED = 2'b10
	} tlps_state_t;
endpackage : tlps_pkg

// *** hw/tlps_proc_queue.sv ***
// first-in first-out queue of ready process identifiers
`timescale 1ns/100ps
`default_nettype none
module tlps_proc_queue
(
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset,
	// filling side
	input  wire logic                        pushValid,
	output logic                             pushReady,
	input  wire logic [tlps_pkg::ID_W-1:0]   pushId,
	// draining side
	output logic                             popValid,
	input  wire logic                        popReady,
	output logic [tlps_pkg::ID_W-1:0]        popId
);
	typedef struct packed
	{
		logic [tlps_pkg::QUEUE_DEPTH-1:0][tlps_pkg::ID_W-1:0] slots;
		logic [tlps_pkg::PTR_W-1:0]                          head;
		logic [tlps_pkg::PTR_W-1:0]                          tail;
	} tlps_queue_t;

	tlps_queue_t q;
	tlps_queue_t next_q;
	logic        full;
	logic        empty;

	assign empty = (q.head == q.tail);
	assign full = (q.head[tlps_pkg::PTR_W-2:0] == q.tail[tlps_pkg::PTR_W-2:0])
		&& (q.head[tlps_pkg::PTR_W-1] != q.tail[tlps_pkg::PTR_W-1]);
	assign pushReady = !full;
	assign popValid = !empty;
	assign popId = q.slots[q.head[tlps_pkg::PTR_W-2:0]];

	always_comb
	begin
		next_q = q;
		if (pushValid && !full)
		begin
			next_q.slots[q.tail[tlps_pkg::PTR_W-2:0]] = pushId;
			next_q.tail = q.tail + 5'h01;
		end
		if (popReady && !empty)
			next_q.head = q.head + 5'h01;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			q <= '0;
		else
			q <= next_q;
	end
endmodule : tlps_proc_queue
`default_nettype wire

// *** testbench/tlps_scheduler_assertions.sv ***
// assertion checker for the two-level process scheduler
`timescale 1ns/100ps
`default_nettype none
module tlps_checker
(
	// scheduler inputs, plus the readyAccept handshake output
	input wire logic	clk,
	input wire logic	reset,
	input wire logic	readyValid,
	input wire logic	readyAccept,
	input wire logic [tlps_pkg::ID_W-1:0]	readyId,
	input wire logic	readyPri,
	input wire logic	procWait,
	input wire logic	procEnd,
	input wire logic	checkFail,
	input wire logic	haltOnError,
	// scheduler outputs
	input wire logic	runValid,
	input wire logic [tlps_pkg::ID_W-1:0]	runId,
	input wire logic	runPri,
	input wire logic	dispatch,
	input wire logic	errorFlag,
	input wire logic	halted,
	input wire logic	linkRun
);
	wire logic	ev = procWait || procEnd;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_link; linkRun; endproperty
	a_link: assert property (p_link) else $error("link engines stalled");
	// the ready queue sits between the port and dispatch, so a start takes two edges
	property p_start; !runValid && !$past(runValid) && !$past(readyValid) && readyValid && readyAccept && !halted
		&& !haltOnError |-> ##2 (dispatch && runId == $past(readyId, 2) && runPri == $past(readyPri, 2)); endproperty
	a_start: assert property (p_start) else $error("idle ready not started");
	property p_keep; runValid && !runPri && !ev && !haltOnError |=> runValid && !dispatch && $stable(runId);
	endproperty
	a_keep: assert property (p_keep) else $error("high process lost the processor");
	property p_pre; runValid && runPri && readyValid && readyAccept && !readyPri && !$past(readyValid)
		&& !ev && !haltOnError |-> ##2 (runValid && !runPri && dispatch); endproperty
	a_pre: assert property (p_pre) else $error("high process not started");
	// a switch in the same cycle may swallow the check, hence the escape terms
	property p_chk; checkFail && runValid && $past(runValid) && !ev && !readyValid && !$past(readyValid)
		&& !halted |=> errorFlag || dispatch || !runValid; endproperty
	a_chk: assert property (p_chk) else $error("failed check left flag clear");
	property p_halt; haltOnError && $rose(errorFlag) |-> ##[0:1] (halted && !runValid); endproperty
	a_halt: assert property (p_halt) else $error("no halt on error");
	property p_stay; halted |=> halted && !runValid && !dispatch; endproperty
	a_stay: assert property (p_stay) else $error("halt not kept");
	property p_save; dispatch && !runPri && $past(runValid && runPri) && !$past(ev)
		|-> errorFlag == $past(errorFlag); endproperty
	a_save: assert property (p_save) else $error("flag changed by pre-emption");
	cover property (dispatch && !runPri && $past(runValid && runPri));
	cover property (dispatch && runPri && $past(runValid && runPri));
	cover property ($rose(halted));
endmodule : tlps_checker
bind tlps_scheduler tlps_checker u_chk (.clk, .reset, .readyValid, .readyAccept, .readyId, .readyPri,
	.procWait, .procEnd, .checkFail, .haltOnError, .runValid, .runId, .runPri, .dispatch, .errorFlag,
	.halted, .linkRun);
`default_nettype wire

// *** testbench/tb_two_level_process_scheduler.sv ***
// self-checking bench of the two-level process scheduler
`timescale 1ns/100ps
`default_nettype none
module tb_two_level_process_scheduler;
	typedef struct packed {logic [3:0] id; logic pri; logic [7:0] exp;} tlps_row_t;
	localparam logic [5:0] RH = 6'h20, RL = 6'h30, PW = 6'h08, PE = 6'h04, CF = 6'h02, EC = 6'h01, NO = 6'h00;
	logic	clk = 1'b0;
	logic	reset = 1'b1;
	logic	refTick = 1'b1;
	logic	readyValid = 1'b0, readyPri = 1'b0, procWait = 1'b0, procEnd = 1'b0;
	logic	checkFail = 1'b0, errorClear = 1'b0, haltOnError = 1'b0;
	logic	[tlps_pkg::ID_W-1:0] readyId = 4'h0;
	logic	[tlps_pkg::ID_W-1:0] runId;
	logic	readyAccept, runValid, runPri, dispatch, errorFlag, halted, linkRun;
	// id and priority mean nothing while idle, so they are masked
	wire logic [7:0]	st = {runValid, runValid & runPri, dispatch, errorFlag, runValid ? runId : 4'h0};
	int	err_total = 0;
	int	cmp_count = 0;
	int	n;
	tlps_row_t	rows [4] = '{'{4'h3, 1'b0, 8'hA3}, '{4'h0, 1'b1, 8'hE0}, '{4'hF, 1'b0, 8'hAF}, '{4'hA, 1'b1, 8'hEA}};
	always #2.5 clk = ~clk;
	tlps_scheduler dut_u (.clk, .reset, .refTick, .readyValid, .readyAccept, .readyId, .readyPri, .procWait,
		.procEnd, .checkFail, .errorClear, .haltOnError, .runValid, .runId, .runPri, .dispatch, .errorFlag,
		.halted, .linkRun);
	task automatic end_sim;
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			$display("unexpected %s expected %h seen %h", nm, exp, got);
			err_total++;
		end
	endtask : chk
	task automatic step(input logic [5:0] c, input logic [3:0] id);
		{readyValid, readyPri, procWait, procEnd, checkFail, errorClear} = c;
		readyId = id;
		@(posedge clk);
		#1;
	endtask : step
	task automatic wait_disp(output int k);
		k = 1;
		step(NO, 4'h0);
		while (dispatch !== 1'b1 && k < 10300)
		begin
			step(NO, 4'h0);
			k++;
		end
		if (k >= 10300)
		begin
			err_total++;
			end_sim;
		end
	endtask : wait_disp
	initial
	begin
		repeat (3) @(posedge clk);
		#1;
		chk("reset state", 8'h00, st);
		chk("reset status", 8'h05, {5'h0, readyAccept, halted, linkRun});
		reset = 1'b0;
		foreach (rows[i])
		begin
			// a ready process is queued first and dispatched at the following edge
			step(rows[i].pri ? RL : RH, rows[i].id);
			chk("row queued", 8'h00, st);
			step(NO, 4'h0);
			chk("row run", rows[i].exp, st);
			step(PE, 4'h0);
			chk("row end", 8'h00, st);
		end
		step(RH, 4'h1);
		step(RL, 4'h7);
		step(RH, 4'h2);
		step(RH, 4'h3);
		chk("high kept", 8'h81, st);
		step(PE, 4'h0);
		chk("fifo head", 8'hA2, st);
		step(PW, 4'h0);
		chk("fifo next", 8'hA3, st);
		step(PE, 4'h0);
		chk("low after high", 8'hE7, st);
		step(PW, 4'h0);
		repeat (3) step(NO, 4'h0);
		chk("waiting idle", 8'h00, st);
		step(RL, 4'h5);
		step(NO, 4'h0);
		step(CF, 4'h0);
		chk("error set", 8'hD5, st);
		step(RH, 4'h2);
		step(NO, 4'h0);
		chk("pre-empt", 8'hB2, st);
		step(EC, 4'h0);
		chk("live cleared", 8'h82, st);
		step(PE, 4'h0);
		chk("resume", 8'hF5, st);
		// errorClear is only honoured while a process runs, so clear before the wait
		step(EC, 4'h0);
		chk("flag cleared", 8'hC5, st);
		step(PW, 4'h0);
		chk("cleared idle", 8'h00, st);
		step(RL, 4'h8);
		step(RL, 4'h9);
		chk("slice start", 8'hE8, st);
		wait_disp(n);
		chk("slice one", 8'h91, {runId, 3'h0, n >= 5118 && n <= 10242});
		wait_disp(n);
		chk("slice two", 8'h81, {runId, 3'h0, n >= 5118 && n <= 10242});
		haltOnError = 1'b1;
		step(NO, 4'h0);
		step(CF, 4'h0);
		chk("halt error", 8'h10, st);
		step(NO, 4'h0);
		chk("halted", 8'h06, {5'h0, halted, linkRun, runValid});
		step(RH, 4'h1);
		step(NO, 4'h0);
		chk("halt kept", 8'h06, {5'h0, halted, linkRun, runValid});
		haltOnError = 1'b0;
		reset = 1'b1;
		step(NO, 4'h0);
		reset = 1'b0;
		chk("reset again", 8'h02, {5'h0, halted, linkRun, runValid});
		// the id queued while halted must be gone, only the new one runs
		step(RH, 4'h6);
		step(NO, 4'h0);
		chk("after reset", 8'hA6, st);
		end_sim;
	end
endmodule : tb_two_level_process_scheduler
`default_nettype wire
